// File: core/sam_pkg.sv
// constants, alarm source table and register map of the servo alarm manager
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package sam_pkg;

	// clock and timing
	localparam int unsigned SAM_CLK_HZ        = 25_000_000;
	localparam int unsigned SAM_DECEL_LIMIT_MS = 10;
	localparam int unsigned SAM_DECEL_LIMIT_CYC = SAM_DECEL_LIMIT_MS * (SAM_CLK_HZ / 1000);

	// alarm sources: 0 uv 10.1, 1 uv bus drop, 2-7 ram 12.1-12.6,
	// 8-10 clock 13.1-13.3, 11-19 control process 14.1-14.9, 20 parameter error 37
	localparam int unsigned SAM_NSRC     = 21;
	localparam int unsigned SAM_NWARN    = 4;   // bit 0 is warning F0
	localparam int unsigned SAM_SRC_PARAM = 20;
	localparam int unsigned SAM_WARN_F0  = 0;

	localparam logic [20:0] SAM_SD_MASK  = 21'h000002; // decel-then-brake sources
	localparam logic [20:0] SAM_CLR_RES  = 21'h100003; // cleared by alarm reset
	localparam logic [20:0] SAM_CLR_CPU  = 21'h100003; // cleared by processor reset
	localparam logic [2:0]  SAM_CODE_UV  = 3'h2;
	localparam logic [2:0]  SAM_CODE_PRM = 3'h1;
	localparam logic [2:0]  SAM_CODE_NONE = 3'h0;

	// history entry ids
	localparam logic [5:0]  SAM_HID_WARN = 6'h20;  // id of warning F0 entry

	// register byte offsets
	localparam logic [7:0] SAM_REG_CTRL     = 8'h00;
	localparam logic [7:0] SAM_REG_ALM      = 8'h04;
	localparam logic [7:0] SAM_REG_WARN     = 8'h08;
	localparam logic [7:0] SAM_REG_INT_STAT = 8'h0c;
	localparam logic [7:0] SAM_REG_INT_MASK = 8'h10;
	localparam logic [7:0] SAM_REG_HIST_SEL = 8'h14;
	localparam logic [7:0] SAM_REG_HIST_DAT = 8'h18;
	localparam logic [7:0] SAM_REG_STOP     = 8'h1c;

	// control fields
	localparam int unsigned SAM_CTRL_CODE_SEL = 0;
	localparam int unsigned SAM_CTRL_ERR_RST  = 1;
	localparam int unsigned SAM_CTRL_CPU_RST  = 2;

	// interrupt fields
	localparam int unsigned SAM_INT_ALM_SET  = 0;
	localparam int unsigned SAM_INT_WARN_SET = 1;
	localparam int unsigned SAM_INT_ALM_CLR  = 2;
	localparam int unsigned SAM_NINT         = 3;

	localparam int unsigned SAM_HIST_DEPTH = 16;

	typedef enum logic [1:0] {
		SAM_RUN,
		SAM_DECEL,
		SAM_BRAKE
	} sam_stop_type;

endpackage

// File: core/sam_hist.sv
// alarm history log: ring of entry ids with a fill count
`timescale 1ns/1ps
module sam_hist
	import sam_pkg::*;
#(
	parameter int unsigned DEPTH = SAM_HIST_DEPTH
) (
	input  wire logic                     mclk_i,
	input  wire logic                     rst_n_i,
	input  wire logic                     log_i,
	input  wire logic [5:0]               id_i,
	input  wire logic [$clog2(DEPTH)-1:0] rd_idx_i,
	output logic      [5:0]               rd_id_o,
	output logic      [$clog2(DEPTH):0]   count_o
);

	localparam int unsigned AW = $clog2(DEPTH);

	logic [5:0]    mem [DEPTH];
	logic [AW-1:0] wptr_r;

	// newest entry overwrites oldest once full
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			wptr_r  <= '0;
			count_o <= '0;
		end else if (log_i) begin
			wptr_r <= wptr_r + 1'b1;
			if (count_o != (AW+1)'(DEPTH)) begin
				count_o <= count_o + 1'b1;
			end
		end
	end

	// storage, no reset needed
	always_ff @(posedge mclk_i) begin
		if (log_i) begin
			mem[wptr_r] <= id_i;
		end
	end

	// index 0 is the most recent entry
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			rd_id_o <= 6'h00;
		end else begin
			rd_id_o <= mem[wptr_r - 1'b1 - rd_idx_i];
		end
	end

endmodule

// File: core/sam_core.sv
// servo alarm manager top: alarm latches, stop sequencing, code output, registers
//
// Implementation choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module sam_core
	import sam_pkg::*;
#(
	parameter int unsigned DECEL_LIMIT_CYC = SAM_DECEL_LIMIT_CYC,
	parameter int unsigned HIST_DEPTH      = SAM_HIST_DEPTH
) (
	input  wire logic                 mclk_i,
	input  wire logic                 rst_n_i,
	// fault causes and warnings, level, high while present
	input  wire logic [SAM_NSRC-1:0]  fault_src_i,
	input  wire logic [SAM_NWARN-1:0] warn_src_i,
	input  wire logic                 fault_clear_input_i,
	input  wire logic                 servo_on_input_i,
	input  wire logic                 zero_speed_i,
	// avalon-mm slave
	input  wire logic [7:0]           avs_address_i,
	input  wire logic                 avs_read_i,
	input  wire logic                 avs_write_i,
	input  wire logic [31:0]          avs_writedata_i,
	input  wire logic [3:0]           avs_byteenable_i,
	output logic      [31:0]          avs_readdata_o,
	output logic                      avs_waitrequest_o,
	// outputs
	output logic                      malfunction_output_o,
	output logic                      decel_then_brake_stop_o,
	output logic                      immediate_brake_stop_o,
	output logic                      fault_code_bit_zero_o,
	output logic                      fault_code_bit_one_o,
	output logic                      fault_code_bit_two_o,
	output logic                      irq_o
);

	localparam int unsigned HAW = $clog2(HIST_DEPTH);

	//--------------------------------------------------------------------------
	// bus access
	//--------------------------------------------------------------------------
	logic                 acc_req;
	logic                 acc_do;
	logic                 wr_do;
	logic                 ctrl_code_sel_r;
	logic [SAM_NINT-1:0]  int_stat_r;
	logic [SAM_NINT-1:0]  int_mask_r;
	logic [HAW-1:0]       hist_sel_r;
	logic [5:0]           hist_id;
	logic [HAW:0]         hist_cnt;
	logic [SAM_NSRC-1:0]  alm_r;
	logic [SAM_NWARN-1:0] warn_r;
	sam_stop_type         stop_r;
	sam_stop_type         stop_nxt;
	logic [31:0]          rd_nxt;

	assign acc_req = avs_read_i | avs_write_i;
	// transfer completes on the edge where waitrequest is seen low
	assign acc_do  = acc_req & ~avs_waitrequest_o;
	assign wr_do   = avs_write_i & acc_do & avs_byteenable_i[0];

	// one wait cycle per access, then a single low cycle
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			avs_waitrequest_o <= 1'b1;
		end else if (acc_req & avs_waitrequest_o) begin
			avs_waitrequest_o <= 1'b0;
		end else begin
			avs_waitrequest_o <= 1'b1;
		end
	end

	// read mux, unmapped offsets read zero
	always_comb begin
		rd_nxt = 32'h0000_0000;
		case (avs_address_i)
			SAM_REG_CTRL:     rd_nxt[SAM_CTRL_CODE_SEL] = ctrl_code_sel_r;
			SAM_REG_ALM:      rd_nxt[SAM_NSRC-1:0] = alm_r;
			SAM_REG_WARN:     rd_nxt[SAM_NWARN-1:0] = warn_r;
			SAM_REG_INT_STAT: rd_nxt[SAM_NINT-1:0] = int_stat_r;
			SAM_REG_INT_MASK: rd_nxt[SAM_NINT-1:0] = int_mask_r;
			SAM_REG_HIST_SEL: rd_nxt[HAW-1:0] = hist_sel_r;
			SAM_REG_HIST_DAT: begin
				rd_nxt[5:0]         = hist_id;  // selected entry id
				rd_nxt[16 +: HAW+1] = hist_cnt; // entries held
			end
			SAM_REG_STOP:     rd_nxt[1:0] = stop_r;
			default:          rd_nxt = 32'h0000_0000;
		endcase
	end

	// read data presented with the low waitrequest cycle
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (avs_read_i & avs_waitrequest_o) begin
			avs_readdata_o <= rd_nxt;
		end
	end

	//--------------------------------------------------------------------------
	// control registers
	//--------------------------------------------------------------------------
	logic err_rst_cmd;
	logic cpu_rst_cmd;
	logic clr_in_d_r;
	logic alm_reset_req;

	assign err_rst_cmd = wr_do & (avs_address_i == SAM_REG_CTRL)
		& avs_writedata_i[SAM_CTRL_ERR_RST];
	assign cpu_rst_cmd = wr_do & (avs_address_i == SAM_REG_CTRL)
		& avs_writedata_i[SAM_CTRL_CPU_RST];
	// rising edge of the reset input or a controller command
	assign alm_reset_req = (fault_clear_input_i & ~clr_in_d_r) | err_rst_cmd;

	// code-select bit, mask and history index
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			ctrl_code_sel_r <= 1'b0;
			int_mask_r      <= '0;
			hist_sel_r      <= '0;
			clr_in_d_r      <= 1'b0;
		end else begin
			clr_in_d_r <= fault_clear_input_i;
			if (wr_do && avs_address_i == SAM_REG_CTRL) begin
				ctrl_code_sel_r <= avs_writedata_i[SAM_CTRL_CODE_SEL];
			end
			if (wr_do && avs_address_i == SAM_REG_INT_MASK) begin
				int_mask_r <= avs_writedata_i[SAM_NINT-1:0];
			end
			if (wr_do && avs_address_i == SAM_REG_HIST_SEL) begin
				hist_sel_r <= avs_writedata_i[HAW-1:0];
			end
		end
	end

	//--------------------------------------------------------------------------
	// alarm latches and warnings
	//--------------------------------------------------------------------------
	logic [SAM_NSRC-1:0] alm_new;
	logic [SAM_NSRC-1:0] clr_ok;

	// power cycle is the reset; other methods per source
	assign clr_ok = ((alm_reset_req ? SAM_CLR_RES : '0)
		| (cpu_rst_cmd ? SAM_CLR_CPU : '0)) & ~fault_src_i;
	assign alm_new = fault_src_i & ~alm_r;

	genvar gi;
	generate
		for (gi = 0; gi < SAM_NSRC; gi++) begin : g_alm
			// cause sets, set wins over any clear
			always_ff @(posedge mclk_i) begin
				if (!rst_n_i) begin
					alm_r[gi] <= 1'b0;
				end else if (fault_src_i[gi]) begin
					alm_r[gi] <= 1'b1;
				end else if (clr_ok[gi]) begin
					alm_r[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// warnings follow their cause, cleared to zero by reset
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			warn_r <= '0;
		end else begin
			warn_r <= warn_src_i;
		end
	end

	//--------------------------------------------------------------------------
	// fault code and malfunction output
	//--------------------------------------------------------------------------
	logic       any_alm_nxt;
	logic [2:0] code_nxt;

	assign any_alm_nxt = |(alm_r & ~clr_ok) | |fault_src_i;

	// code of lowest numbered latched alarm; warnings never counted
	always_comb begin
		code_nxt = SAM_CODE_NONE;
		for (int i = SAM_NSRC - 1; i >= 0; i--) begin
			if (alm_r[i] | fault_src_i[i]) begin
				if (i <= 1) begin
					code_nxt = SAM_CODE_UV;
				end else if (i == SAM_SRC_PARAM) begin
					code_nxt = SAM_CODE_PRM;
				end else begin
					code_nxt = SAM_CODE_NONE;
				end
			end
		end
	end

	// outputs registered from next-state alarm view
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			malfunction_output_o  <= 1'b1;
			fault_code_bit_zero_o <= 1'b0;
			fault_code_bit_one_o  <= 1'b0;
			fault_code_bit_two_o  <= 1'b0;
		end else begin
			malfunction_output_o <= ~any_alm_nxt;
			if (ctrl_code_sel_r && any_alm_nxt) begin
				fault_code_bit_zero_o <= code_nxt[0];
				fault_code_bit_one_o  <= code_nxt[1];
				fault_code_bit_two_o  <= code_nxt[2];
			end else begin
				fault_code_bit_zero_o <= 1'b0;
				fault_code_bit_one_o  <= 1'b0;
				fault_code_bit_two_o  <= 1'b0;
			end
		end
	end

	//--------------------------------------------------------------------------
	// stop sequencing
	//--------------------------------------------------------------------------
	logic        imm_alm;
	logic        sd_alm;
	logic [31:0] decel_cnt_r;

	assign imm_alm = |((alm_r | fault_src_i) & ~SAM_SD_MASK);
	assign sd_alm  = |((alm_r | fault_src_i) & SAM_SD_MASK);

	// stop method selection; brake holds until alarms clear
	always_comb begin
		stop_nxt = stop_r;
		case (stop_r)
			SAM_RUN: begin
				if (imm_alm || (sd_alm && !servo_on_input_i)) begin
					stop_nxt = SAM_BRAKE;
				end else if (sd_alm) begin
					stop_nxt = SAM_DECEL;
				end
			end
			SAM_DECEL: begin
				if (imm_alm) begin
					stop_nxt = SAM_BRAKE;
				end else if (!any_alm_nxt) begin
					stop_nxt = SAM_RUN;
				end else if (zero_speed_i || decel_cnt_r >= DECEL_LIMIT_CYC - 1) begin
					stop_nxt = SAM_BRAKE;
				end
			end
			SAM_BRAKE: begin
				if (!any_alm_nxt) begin
					stop_nxt = SAM_RUN;
				end
			end
			default: stop_nxt = SAM_BRAKE;
		endcase
	end

	// state, decel timer and stop outputs
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			stop_r                  <= SAM_RUN;
			decel_cnt_r             <= 32'h0000_0000;
			decel_then_brake_stop_o <= 1'b0;
			immediate_brake_stop_o  <= 1'b0;
		end else begin
			stop_r                  <= stop_nxt;
			decel_then_brake_stop_o <= (stop_nxt == SAM_DECEL);
			immediate_brake_stop_o  <= (stop_nxt == SAM_BRAKE);
			if (stop_r == SAM_DECEL) begin
				decel_cnt_r <= decel_cnt_r + 32'h0000_0001;
			end else begin
				decel_cnt_r <= 32'h0000_0000;
			end
		end
	end

	//--------------------------------------------------------------------------
	// history log
	//--------------------------------------------------------------------------
	logic [SAM_NSRC-1:0] alm_logged;
	logic                log_ev;
	logic [5:0]          log_id;

	// parameter error and warnings other than F0 are not logged
	assign alm_logged = alm_new & ~(21'h000001 << SAM_SRC_PARAM);

	always_comb begin
		log_ev = 1'b0;
		log_id = 6'h00;
		if (warn_src_i[SAM_WARN_F0] && !warn_r[SAM_WARN_F0]) begin
			log_ev = 1'b1;
			log_id = SAM_HID_WARN;
		end
		for (int i = SAM_NSRC - 1; i >= 0; i--) begin
			if (alm_logged[i]) begin
				log_ev = 1'b1;
				log_id = 6'(i);
			end
		end
	end

	sam_hist #(
		.DEPTH (HIST_DEPTH)
	) u_hist (
		.mclk_i   (mclk_i),
		.rst_n_i  (rst_n_i),
		.log_i    (log_ev),
		.id_i     (log_id),
		.rd_idx_i (hist_sel_r),
		.rd_id_o  (hist_id),
		.count_o  (hist_cnt)
	);

	//--------------------------------------------------------------------------
	// interrupts
	//--------------------------------------------------------------------------
	logic [SAM_NINT-1:0] int_set;
	logic [SAM_NINT-1:0] int_w1c;

	assign int_set[SAM_INT_ALM_SET]  = |alm_new;
	assign int_set[SAM_INT_WARN_SET] = |(warn_src_i & ~warn_r);
	assign int_set[SAM_INT_ALM_CLR]  = (|alm_r) & ~any_alm_nxt;
	assign int_w1c = (wr_do && avs_address_i == SAM_REG_INT_STAT)
		? avs_writedata_i[SAM_NINT-1:0] : '0;

	// sticky status, set wins over write-one-to-clear
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			int_stat_r <= '0;
			irq_o      <= 1'b0;
		end else begin
			int_stat_r <= (int_stat_r & ~int_w1c) | int_set;
			irq_o      <= |(((int_stat_r & ~int_w1c) | int_set) & int_mask_r);
		end
	end

endmodule

// File: sim/sam_core_assertions.sv
// checker: port-level properties of the servo alarm manager
`timescale 1ns/1ps
module sam_core_assertions
	import sam_pkg::*;
(
	input wire logic                mclk_i,
	input wire logic                rst_n_i,
	input wire logic [SAM_NSRC-1:0] fault_src_i,
	input wire logic                fault_clear_input_i,
	input wire logic                servo_on_input_i,
	input wire logic                avs_read_i,
	input wire logic                avs_write_i,
	input wire logic                avs_waitrequest_o,
	input wire logic                malfunction_output_o,
	input wire logic                decel_then_brake_stop_o,
	input wire logic                immediate_brake_stop_o,
	input wire logic                fault_code_bit_zero_o,
	input wire logic                fault_code_bit_one_o,
	input wire logic                fault_code_bit_two_o
);
	// ---------------------------------------------------------------
	// properties
	// ---------------------------------------------------------------
	wire [2:0] code = {fault_code_bit_two_o, fault_code_bit_one_o, fault_code_bit_zero_o};
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	alarm_drop_a: assert property (|fault_src_i |=> !malfunction_output_o)
		else $error("alarm left malfunction output high");
	brake_direct_a: assert property (fault_src_i[0] && malfunction_output_o
		|=> immediate_brake_stop_o && !decel_then_brake_stop_o)
		else $error("immediate fault did not brake at once");
	decel_first_a: assert property ((fault_src_i == 21'h000002) && malfunction_output_o
		&& servo_on_input_i |=> decel_then_brake_stop_o && !immediate_brake_stop_o)
		else $error("bus drop fault did not decelerate first");
	decel_end_a: assert property ($rose(decel_then_brake_stop_o)
		|-> ##[1:24] (!decel_then_brake_stop_o && immediate_brake_stop_o))
		else $error("deceleration not followed by brake");
	code_idle_a: assert property ((code != 3'h0) |-> !malfunction_output_o)
		else $error("code shown with no alarm");
	warn_quiet_a: assert property ((fault_src_i == '0) && malfunction_output_o
		|=> malfunction_output_o && (code == 3'h0))
		else $error("alarm or code without a fault");
	latch_hold_a: assert property (!malfunction_output_o && !avs_write_i &&
		!$past(avs_write_i) && !fault_clear_input_i && !$past(fault_clear_input_i)
		|=> !malfunction_output_o)
		else $error("alarm dropped without a clear event");
	bus_wait_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o)
		else $error("bus answer not after one wait cycle");
endmodule

bind sam_core sam_core_assertions u_sam_core_assertions (
	.mclk_i                  (mclk_i),
	.rst_n_i                 (rst_n_i),
	.fault_src_i             (fault_src_i),
	.fault_clear_input_i     (fault_clear_input_i),
	.servo_on_input_i        (servo_on_input_i),
	.avs_read_i              (avs_read_i),
	.avs_write_i             (avs_write_i),
	.avs_waitrequest_o       (avs_waitrequest_o),
	.malfunction_output_o    (malfunction_output_o),
	.decel_then_brake_stop_o (decel_then_brake_stop_o),
	.immediate_brake_stop_o  (immediate_brake_stop_o),
	.fault_code_bit_zero_o   (fault_code_bit_zero_o),
	.fault_code_bit_one_o    (fault_code_bit_one_o),
	.fault_code_bit_two_o    (fault_code_bit_two_o)
);

// File: sim/sam_ctrl_model.sv
// model of the motion controller and discrete i/o around the alarm manager
`timescale 1ns/1ps
module sam_ctrl_model (
	input  wire logic mclk_i,
	input  wire logic rst_n_i,
	input  wire logic clear_req_i,
	input  wire logic slow_i,
	input  wire logic malfunction_output_i,
	input  wire logic decel_i,
	output logic      fault_clear_o,
	output logic      servo_on_o,
	output logic      zero_speed_o
);
	logic [3:0] decel_cnt_r;
	logic [1:0] clr_cnt_r;

	// servo-on withdrawn one cycle after an alarm shows, restored once clear
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) servo_on_o <= 1'b1;
		else servo_on_o <= malfunction_output_i;
	end

	// reset button held three cycles per request
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) clr_cnt_r <= 2'h0;
		else if (clear_req_i) clr_cnt_r <= 2'h3;
		else if (clr_cnt_r != 2'h0) clr_cnt_r <= clr_cnt_r - 2'h1;
	end
	assign fault_clear_o = (clr_cnt_r != 2'h0);

	// motor reaches zero speed a few cycles into deceleration, never when slow
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i || !decel_i) decel_cnt_r <= 4'h0;
		else if (decel_cnt_r != 4'hf) decel_cnt_r <= decel_cnt_r + 4'h1;
	end
	assign zero_speed_o = decel_i ? (!slow_i && decel_cnt_r >= 4'h3) : !servo_on_o;
endmodule

// File: sim/tb.sv
// self-checking testbench of the servo alarm manager
`timescale 1ns/1ps
module tb;
	import sam_pkg::*;
	logic                mclk_i, rst_n_i, rd, wr, wreq, malf, decel, brake, c0, c1, c2;
	logic                irq, fclr, servo_on_input, zspd, clear_req, slow;
	logic [SAM_NSRC-1:0] fsrc;
	logic [3:0]          wsrc;
	logic [7:0]          addr;
	logic [31:0]         wdat, rdat, q;
	int                  n_mismatch, checks_done, cyc;

	sam_core #(.DECEL_LIMIT_CYC(20), .HIST_DEPTH(16)) u_sam_core (.mclk_i(mclk_i),
		.rst_n_i(rst_n_i), .fault_src_i(fsrc), .warn_src_i(wsrc), .fault_clear_input_i(fclr),
		.servo_on_input_i(servo_on_input), .zero_speed_i(zspd), .avs_address_i(addr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .malfunction_output_o(malf),
		.decel_then_brake_stop_o(decel), .immediate_brake_stop_o(brake),
		.fault_code_bit_zero_o(c0), .fault_code_bit_one_o(c1), .fault_code_bit_two_o(c2),
		.irq_o(irq));
	sam_ctrl_model u_sam_ctrl_model (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.clear_req_i(clear_req), .slow_i(slow), .malfunction_output_i(malf),
		.decel_i(decel), .fault_clear_o(fclr), .servo_on_o(servo_on_input), .zero_speed_o(zspd));

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task outs(input logic [5:0] e);
		chk("outputs", {26'h0, e}, {26'h0, malf, decel, brake, c2, c1, c0});
	endtask
	task nap(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	task fset(input logic [SAM_NSRC-1:0] v);
		@(posedge mclk_i);
		fsrc <= v;
	endtask
	// one avalon access, held until the rising edge that sees waitrequest low
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk_i);
		addr <= a;
		wdat <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge mclk_i);
			n++;
		end while (wreq !== 1'b0);
		q = rdat;
		chk("wait cycles", 32'h2, n);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk("readdata", e, q);
	endtask
	task do_reset();
		@(posedge mclk_i);
		rst_n_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		rst_n_i <= 1'b1;
	endtask
	task pulse_clear();
		@(posedge mclk_i);
		clear_req <= 1'b1;
		@(posedge mclk_i);
		clear_req <= 1'b0;
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task t_decel();
		bus(1'b1, SAM_REG_CTRL, 32'h1);
		fset(21'h2);
		nap(2);
		outs({3'h2, SAM_CODE_UV});
		nap(8);
		outs({3'h1, SAM_CODE_UV});
		fset(21'h0);
		nap(3);
		outs({3'h1, SAM_CODE_UV});
		pulse_clear();
		nap(6);
		outs({3'h4, SAM_CODE_NONE});
		slow <= 1'b1;
		fset(21'h2);
		nap(12);
		outs({3'h2, SAM_CODE_UV});
		nap(14);
		outs({3'h1, SAM_CODE_UV});
		fset(21'h0);
		bus(1'b1, SAM_REG_CTRL, 32'h3);
		nap(3);
		outs({3'h4, SAM_CODE_NONE});
		slow <= 1'b0;
		$display("test decel done");
	endtask
	task t_brake();
		for (int i = 0; i <= 20; i += 20) begin
			fset(21'h1 << i);
			nap(2);
			outs({3'h1, (i == 0) ? SAM_CODE_UV : SAM_CODE_PRM});
			bus(1'b1, SAM_REG_CTRL, 32'h7);
			nap(3);
			outs({3'h1, (i == 0) ? SAM_CODE_UV : SAM_CODE_PRM});
			fset(21'h0);
			bus(1'b1, SAM_REG_CTRL, (i == 0) ? 32'h3 : 32'h5);
			nap(3);
			outs({3'h4, SAM_CODE_NONE});
		end
		$display("test brake done");
	endtask
	task t_power();
		for (int i = 2; i < 20; i++) begin
			do_reset();
			bus(1'b1, SAM_REG_CTRL, 32'h1);
			fset(21'h1 << i);
			nap(2);
			outs({3'h1, SAM_CODE_NONE});
			fset(21'h0);
			bus(1'b1, SAM_REG_CTRL, 32'h7);
			pulse_clear();
			nap(6);
			outs({3'h1, SAM_CODE_NONE});
		end
		do_reset();
		nap(1);
		outs({3'h4, SAM_CODE_NONE});
		$display("test power done");
	endtask
	task t_warn();
		bus(1'b1, SAM_REG_CTRL, 32'h1);
		@(posedge mclk_i);
		wsrc <= 4'hf;
		nap(3);
		outs({3'h4, SAM_CODE_NONE});
		rdc(SAM_REG_WARN, 32'hf);
		@(posedge mclk_i);
		wsrc <= 4'h0;
		nap(3);
		rdc(SAM_REG_WARN, 32'h0);
		$display("test warn done");
	endtask
	task t_hist();
		do_reset();
		bus(1'b1, SAM_REG_HIST_SEL, 32'h0);
		fset(21'h1 << SAM_SRC_PARAM);
		nap(2);
		fset(21'h0);
		bus(1'b1, SAM_REG_CTRL, 32'h3);
		@(posedge mclk_i);
		wsrc <= 4'h3;
		nap(2);
		@(posedge mclk_i);
		wsrc <= 4'h0;
		bus(1'b0, SAM_REG_HIST_DAT, 32'h0);
		chk("history", {11'h0, 5'h1, 10'h0, SAM_HID_WARN}, q & 32'h001f003f);
		$display("test hist done");
	endtask
	task t_irq();
		do_reset();
		bus(1'b1, SAM_REG_INT_MASK, 32'h0);
		fset(21'h1);
		nap(2);
		fset(21'h0);
		bus(1'b1, SAM_REG_CTRL, 32'h3);
		nap(2);
		rdc(SAM_REG_INT_STAT, 32'h5);
		chk("irq", 32'h0, {31'h0, irq});
		// a set mask bit lets its status bit through to the interrupt
		bus(1'b1, SAM_REG_INT_MASK, 32'h7);
		nap(2);
		chk("irq", 32'h1, {31'h0, irq});
		bus(1'b1, SAM_REG_INT_MASK, 32'h0);
		bus(1'b1, SAM_REG_INT_STAT, 32'h5);
		rdc(SAM_REG_INT_STAT, 32'h0);
		chk("irq", 32'h0, {31'h0, irq});
		rdc(8'hfc, 32'h0);
		$display("test irq done");
	endtask

	task end_sim();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// clock, hang guard and main sequence
	initial begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 8000) begin
			n_mismatch++;
			end_sim();
		end
	end
	initial begin
		{rst_n_i, rd, wr, clear_req, slow, addr, wdat, fsrc, wsrc} = '0;
		{n_mismatch, checks_done, cyc} = '0;
		do_reset();
		nap(1);
		outs({3'h4, SAM_CODE_NONE});
		t_decel();
		t_brake();
		t_warn();
		t_power();
		t_hist();
		t_irq();
		end_sim();
	end
endmodule
